// file: src/vds_pkg.sv
// shared constants, types and register map of the video status bank
package vds_pkg;

    // register sub-addresses on the serial control port
    localparam logic [7:0] VDS_SUB_REQUEST = 8'h1F;
    localparam logic [7:0] VDS_SUB_VIDEO_STATUS = 8'h20;
    localparam logic [7:0] VDS_SUB_SERVICE_STATUS = 8'h21;
    localparam logic [7:0] VDS_SUB_CAPTION_LOW = 8'h22;
    localparam logic [7:0] VDS_SUB_CAPTION_HIGH = 8'h23;

    // reset values and the value read from unmapped sub-addresses
    localparam logic [7:0] VDS_VIDEO_STATUS_RST = 8'h00;
    localparam logic [7:0] VDS_SERVICE_STATUS_RST = 8'h00;
    localparam logic [7:0] VDS_CAPTION_RST = 8'h00;
    localparam logic [7:0] VDS_UNMAPPED_READ = 8'h00;

    // video status field positions
    localparam int VDS_VS_NO_INPUT = 0;
    localparam int VDS_VS_LOCKED = 1;
    localparam int VDS_VS_FRAME_STD = 2;
    localparam int VDS_VS_NONSTD = 3;
    localparam int VDS_VS_CLK_LO = 4;
    localparam int VDS_VS_CLK_HI = 5;
    localparam int VDS_VS_FIELD = 6;
    localparam int VDS_VS_KILLER = 7;

    // service status field positions, also request bit positions
    localparam int VDS_SVC_ASPECT = 0;
    localparam int VDS_SVC_CAPTION = 1;
    localparam int VDS_SVC_EXTENDED = 2;
    localparam int VDS_SVC_LINE_ID = 3;
    localparam int VDS_SVC_WSS = 4;
    localparam int VDS_SS_RESERVED = 5;
    localparam int VDS_SS_PROTECT_LO = 6;
    localparam int VDS_SS_PROTECT_HI = 7;
    localparam int VDS_NUM_SERVICES = 5;

    // serial port framing
    localparam logic [3:0] VDS_BITS_PER_BYTE = 4'h8;
    localparam logic [6:0] VDS_DEV_ADDR_DEFAULT = 7'h22;

    // active clock mode codes
    typedef enum logic [1:0] {
        VDS_CLK_FIXED = 2'b00,
        VDS_CLK_LINE = 2'b01,
        VDS_CLK_RESERVED = 2'b10,
        VDS_CLK_FRAME = 2'b11
    } vds_clk_mode_t;

    // serial engine states, one-hot
    typedef enum logic [8:0] {
        VDS_ST_IDLE = 9'b0_0000_0001,
        VDS_ST_ADDR = 9'b0_0000_0010,
        VDS_ST_ADDR_ACK = 9'b0_0000_0100,
        VDS_ST_SUB = 9'b0_0000_1000,
        VDS_ST_SUB_ACK = 9'b0_0001_0000,
        VDS_ST_WDATA = 9'b0_0010_0000,
        VDS_ST_WDATA_ACK = 9'b0_0100_0000,
        VDS_ST_RDATA = 9'b0_1000_0000,
        VDS_ST_RDATA_ACK = 9'b1_0000_0000
    } vds_state_t;

    // live state reported by the decoder core
    typedef struct packed {
        logic no_input;
        logic vertical_sync_locked;
        logic frame_standard_ok;
        logic nonstandard_raw;
        logic component_input;
        vds_clk_mode_t clock_mode;
        logic even_field;
        logic colour_killer_active;
        logic aspect_level;
        logic analog_protect_status_hi;
        logic analog_protect_status_lo;
    } vds_core_state_t;

    // completion pulses and decoded caption word from the slicer
    typedef struct packed {
        logic [VDS_NUM_SERVICES-1:0] done;
        logic [15:0] caption_word;
    } vds_vbi_result_t;

endpackage : vds_pkg

// file: src/vds_found_flag.sv
// arm and found flag of one data service
`timescale 1ns/1ps
`default_nettype none
module vds_found_flag (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // request and completion
    input wire logic request,
    input wire logic done,
    // status
    output logic found,
    output logic capture
);
    import vds_pkg::*;

    logic armed;

    // a completion only counts while a request is outstanding
    assign capture = done && armed;

    // arming: a request waits for the next decoded line
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            armed <= 1'b0;
        end else if (request) begin
            armed <= 1'b1;
        end else if (capture) begin
            armed <= 1'b0;
        end
    end

    // found: set wins over the clear of a fresh request
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            found <= 1'b0;
        end else if (capture) begin
            found <= 1'b1;
        end else if (request) begin
            found <= 1'b0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // an outstanding request; a fresh one in the same cycle must not win
    sequence arm_s;
        armed;
    endsequence
    sequence complete_s;
        done [*1];
    endsequence

    found_sets_a: assert property (
        arm_s ##0 complete_s |=> found)
        else $error("found flag not set after armed completion");
    found_holds_a: assert property (
        found && !request |=> found)
        else $error("found flag dropped without a new request");

endmodule : vds_found_flag
`default_nettype wire

// file: src/vds_caption_store.sv
// holding registers for the decoded caption word
`timescale 1ns/1ps
`default_nettype none
module vds_caption_store (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // capture strobe and word
    input wire logic capture,
    input wire logic [15:0] word_in,
    // stored bytes
    output logic [7:0] caption_data_low,
    output logic [7:0] caption_data_high
);
    import vds_pkg::*;

    // only a completed, requested decode updates the bytes
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            caption_data_low <= VDS_CAPTION_RST;
            caption_data_high <= VDS_CAPTION_RST;
        end else if (capture) begin
            caption_data_low <= word_in[7:0];
            caption_data_high <= word_in[15:8];
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    caption_capture_a: assert property (
        capture |=> {caption_data_high, caption_data_low} == $past(word_in))
        else $error("caption word not stored on capture");
    caption_hold_a: assert property (
        !capture |=> $stable({caption_data_high, caption_data_low}))
        else $error("caption bytes changed without capture");

endmodule : vds_caption_store
`default_nettype wire

// file: src/vds_status_bank.sv
// video decoder status register bank behind the serial control port
//
// Function
// - read-only video status register at 0x20 shows live decoder state.
// - bit 0 reads 1 when no input signal is present.
// - no-input bit is also driven on its own output pin.
// - bit 1 reads 1 while synchronised to the incoming signal.
// - bit 2 reads 1 for 525 or 625 line interlaced input.
// - bit 3 flags non-standard input from the subcarrier phase check.
// - non-standard bit is also driven on its own output pin.
// - bits 5:4 give clock mode; reserved code 10 never reported.
// - bit 6 reads 0 in odd field, 1 in even field.
// - bit 7 reads 1 while the colour killer is active.
// - read-only service status register at 0x21 holds detection flags.
// - service bit 0 gives aspect level, 0 normal, 1 wide.
// - service bit 1 reads 1 once caption data is found.
// - service bit 2 reads 1 once extended data is found.
// - service bit 3 reads 1 once line-ID data is found.
// - service bit 4 reads 1 once WSS data is found.
// - 0x22 and 0x23 hold decoded caption word, low byte at 0x22.
// - request bit arms a service; completion sets flag; only caption and aspect store data.
// - 0x23 holds caption bits 15..8, read only.
`timescale 1ns/1ps
`default_nettype none
module vds_status_bank #(
    parameter logic [6:0] DEV_ADDR_BASE = vds_pkg::VDS_DEV_ADDR_DEFAULT
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // decoder core state and slicer results
    input wire vds_pkg::vds_core_state_t core_state,
    input wire vds_pkg::vds_vbi_result_t vbi_result,
    // serial control port
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic addr_select,
    // status pins
    output logic no_input_pin,
    output logic nonstandard_pin
);
    import vds_pkg::*;

    // register contents
    logic [7:0] video_status;
    logic [7:0] service_status;
    logic [7:0] next_video_status;
    logic [7:0] next_service_status;
    logic [7:0] caption_data_low;
    logic [7:0] caption_data_high;
    logic aspect_data;

    // service request and detection
    logic [VDS_NUM_SERVICES-1:0] request_pulse;
    logic [VDS_NUM_SERVICES-1:0] found;
    logic [VDS_NUM_SERVICES-1:0] capture;

    // serial engine
    vds_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] sub_addr;
    logic is_read;
    logic master_ack;
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic addr_match;
    logic byte_done;
    logic byte_write;

    // read multiplexer; anything outside the bank reads as zero
    function automatic logic [7:0] vds_read_byte(
        input logic [7:0] sub,
        input logic [7:0] vs,
        input logic [7:0] ss,
        input logic [7:0] cl,
        input logic [7:0] ch
    );
        logic [7:0] result;
        result = VDS_UNMAPPED_READ;
        case (sub)
            VDS_SUB_VIDEO_STATUS: result = vs;
            VDS_SUB_SERVICE_STATUS: result = ss;
            VDS_SUB_CAPTION_LOW: result = cl;
            VDS_SUB_CAPTION_HIGH: result = ch;
            default: result = VDS_UNMAPPED_READ;
        endcase
        return result;
    endfunction : vds_read_byte

    // next value of the video status word, sampled from the core each cycle
    always_comb begin
        next_video_status = video_status;
        next_video_status[VDS_VS_NO_INPUT] = core_state.no_input;
        next_video_status[VDS_VS_LOCKED] =
            core_state.vertical_sync_locked;
        next_video_status[VDS_VS_FRAME_STD] =
            core_state.frame_standard_ok;
        // component input never flags a proper frame as non-standard
        if (core_state.component_input && core_state.frame_standard_ok) begin
            next_video_status[VDS_VS_NONSTD] = 1'b0;
        end else begin
            next_video_status[VDS_VS_NONSTD] =
                core_state.nonstandard_raw;
        end
        // the reserved code keeps the last legal mode rather than leak out
        if (core_state.clock_mode != VDS_CLK_RESERVED) begin
            next_video_status[VDS_VS_CLK_HI:VDS_VS_CLK_LO] =
                core_state.clock_mode;
        end
        next_video_status[VDS_VS_FIELD] = core_state.even_field;
        next_video_status[VDS_VS_KILLER] =
            core_state.colour_killer_active;
    end

    // next value of the service status word
    always_comb begin
        next_service_status = VDS_SERVICE_STATUS_RST;
        next_service_status[VDS_SVC_ASPECT] = aspect_data;
        next_service_status[VDS_SVC_CAPTION] =
            found[VDS_SVC_CAPTION];
        next_service_status[VDS_SVC_EXTENDED] =
            found[VDS_SVC_EXTENDED];
        next_service_status[VDS_SVC_LINE_ID] =
            found[VDS_SVC_LINE_ID];
        next_service_status[VDS_SVC_WSS] = found[VDS_SVC_WSS];
        next_service_status[VDS_SS_RESERVED] = 1'b0;
        next_service_status[VDS_SS_PROTECT_LO] =
            core_state.analog_protect_status_lo;
        next_service_status[VDS_SS_PROTECT_HI] =
            core_state.analog_protect_status_hi;
    end

    // status registers and pins load together so they always agree
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            video_status <= VDS_VIDEO_STATUS_RST;
            service_status <= VDS_SERVICE_STATUS_RST;
            no_input_pin <= VDS_VIDEO_STATUS_RST[VDS_VS_NO_INPUT];
            nonstandard_pin <= VDS_VIDEO_STATUS_RST[VDS_VS_NONSTD];
        end else begin
            video_status <= next_video_status;
            service_status <= next_service_status;
            no_input_pin <= next_video_status[VDS_VS_NO_INPUT];
            nonstandard_pin <= next_video_status[VDS_VS_NONSTD];
        end
    end

    // aspect level is latched when an aspect request completes
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            aspect_data <= 1'b0;
        end else if (capture[VDS_SVC_ASPECT]) begin
            aspect_data <= core_state.aspect_level;
        end
    end

    // one arm/found pair per service; the aspect found flag is not shown
    for (genvar i = 0; i < VDS_NUM_SERVICES; i++) begin : g_service
        vds_found_flag u_flag (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .request(request_pulse[i]),
            .done(vbi_result.done[i]),
            .found(found[i]),
            .capture(capture[i])
        );
    end

    // caption holding registers
    vds_caption_store u_caption (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .capture(capture[VDS_SVC_CAPTION]),
        .word_in(vbi_result.caption_word),
        .caption_data_low(caption_data_low),
        .caption_data_high(caption_data_high)
    );

    // bus line events; pins are already in the core clock domain
    assign scl_rise = scl_in && !scl_q;
    assign scl_fall = !scl_in && scl_q;
    assign start_seen = scl_in && scl_q && sda_q && !sda_in;
    assign stop_seen = scl_in && scl_q && !sda_q && sda_in;
    assign addr_match = shreg[7:1] == {DEV_ADDR_BASE[6:1], addr_select};
    assign byte_done = bit_cnt == VDS_BITS_PER_BYTE;
    assign byte_write = scl_fall && state == VDS_ST_WDATA && byte_done;

    // previous line levels for edge and condition detection
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // request bits are one-cycle strobes from a data byte at 0x1F
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            request_pulse <= '0;
        end else if (byte_write && sub_addr == VDS_SUB_REQUEST) begin
            request_pulse <= shreg[VDS_NUM_SERVICES-1:0];
        end else begin
            request_pulse <= '0;
        end
    end

    // the data line is open drain: it only ever pulls low
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // serial engine: address, sub-address, then data bytes
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state <= VDS_ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            sub_addr <= 8'h00;
            is_read <= 1'b0;
            master_ack <= 1'b0;
            sda_oe_n <= 1'b1;
        end else if (start_seen) begin
            state <= VDS_ST_ADDR;
            bit_cnt <= 4'h0;
            sda_oe_n <= 1'b1;
        end else if (stop_seen) begin
            state <= VDS_ST_IDLE;
            sda_oe_n <= 1'b1;
        end else if (scl_rise) begin
            case (state)
                VDS_ST_ADDR, VDS_ST_SUB, VDS_ST_WDATA: begin
                    shreg <= {shreg[6:0], sda_in};
                    bit_cnt <= bit_cnt + 4'h1;
                end
                VDS_ST_RDATA: begin
                    bit_cnt <= bit_cnt + 4'h1;
                end
                VDS_ST_RDATA_ACK: begin
                    master_ack <= !sda_in;
                end
                default: begin
                    bit_cnt <= bit_cnt;
                end
            endcase
        end else if (scl_fall) begin
            case (state)
                VDS_ST_ADDR: begin
                    if (byte_done && addr_match) begin
                        state <= VDS_ST_ADDR_ACK;
                        is_read <= shreg[0];
                        sda_oe_n <= 1'b0;
                    end else if (byte_done) begin
                        state <= VDS_ST_IDLE;
                    end
                end
                VDS_ST_ADDR_ACK: begin
                    bit_cnt <= 4'h0;
                    if (is_read) begin
                        // reading only copies a snapshot; nothing is cleared
                        shreg <= vds_read_byte(sub_addr, video_status,
                            service_status, caption_data_low,
                            caption_data_high);
                        state <= VDS_ST_RDATA;
                        sda_oe_n <= vds_read_byte(sub_addr, video_status,
                            service_status, caption_data_low,
                            caption_data_high) >= 8'h80;
                    end else begin
                        state <= VDS_ST_SUB;
                        sda_oe_n <= 1'b1;
                    end
                end
                VDS_ST_SUB: begin
                    if (byte_done) begin
                        sub_addr <= shreg;
                        state <= VDS_ST_SUB_ACK;
                        sda_oe_n <= 1'b0;
                    end
                end
                VDS_ST_SUB_ACK, VDS_ST_WDATA_ACK: begin
                    state <= VDS_ST_WDATA;
                    bit_cnt <= 4'h0;
                    sda_oe_n <= 1'b1;
                end
                VDS_ST_WDATA: begin
                    // writes to other registers are acked and dropped
                    if (byte_done) begin
                        sub_addr <= sub_addr + 8'h01;
                        state <= VDS_ST_WDATA_ACK;
                        sda_oe_n <= 1'b0;
                    end
                end
                VDS_ST_RDATA: begin
                    if (byte_done) begin
                        sub_addr <= sub_addr + 8'h01;
                        state <= VDS_ST_RDATA_ACK;
                        sda_oe_n <= 1'b1;
                    end else begin
                        sda_oe_n <= shreg[3'(4'h7 - bit_cnt)];
                    end
                end
                VDS_ST_RDATA_ACK: begin
                    bit_cnt <= 4'h0;
                    if (master_ack) begin
                        shreg <= vds_read_byte(sub_addr, video_status,
                            service_status, caption_data_low,
                            caption_data_high);
                        state <= VDS_ST_RDATA;
                        sda_oe_n <= vds_read_byte(sub_addr, video_status,
                            service_status, caption_data_low,
                            caption_data_high) >= 8'h80;
                    end else begin
                        state <= VDS_ST_IDLE;
                        sda_oe_n <= 1'b1;
                    end
                end
                default: begin
                    sda_oe_n <= 1'b1;
                end
            endcase
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence addr_taken_s;
        scl_fall && state == VDS_ST_ADDR && byte_done && addr_match;
    endsequence

    pins_match_a: assert property (
        no_input_pin == video_status[VDS_VS_NO_INPUT] &&
        nonstandard_pin == video_status[VDS_VS_NONSTD])
        else $error("status pins disagree with register");
    lock_follows_a: assert property (
        ##1 video_status[VDS_VS_LOCKED] ==
        $past(core_state.vertical_sync_locked))
        else $error("lock bit does not track core");
    clock_mode_legal_a: assert property (
        video_status[VDS_VS_CLK_HI:VDS_VS_CLK_LO] != VDS_CLK_RESERVED)
        else $error("reserved clock mode reported");
    component_force_a: assert property (
        core_state.component_input && core_state.frame_standard_ok |=>
        !video_status[VDS_VS_NONSTD])
        else $error("non-standard flag not forced low");
    field_tracks_a: assert property (
        ##1 video_status[VDS_VS_FIELD] == $past(core_state.even_field))
        else $error("field bit does not track core");
    reserved_zero_a: assert property (
        !service_status[VDS_SS_RESERVED])
        else $error("reserved service bit set");
    found_shown_a: assert property (
        capture[VDS_SVC_CAPTION] |=> ##1 service_status[VDS_SVC_CAPTION])
        else $error("caption found not shown");
    addr_ack_a: assert property (addr_taken_s |=> !sda_oe_n)
        else $error("address not acknowledged");

endmodule : vds_status_bank
`default_nettype wire

// file: tb/vds_status_bank_bench.sv
// self-checking bench of the video status register bank
`timescale 1ns/1ps
`default_nettype none
module vds_status_bank_bench;
    import vds_pkg::*;
    localparam logic [6:0] DA = {VDS_DEV_ADDR_DEFAULT[6:1], 1'b0};
    logic core_clk, rst_n, scl, sda_m;
    vds_core_state_t cs;
    vds_vbi_result_t vr;
    wire logic sda_out, sda_oe_n, nin_pin, nonstandard_input_flag_pin;
    // open drain: the line is low if either party pulls it
    wire logic sda = sda_m & (sda_oe_n | sda_out);
    logic [7:0] rd_data;
    logic [7:0] exp_q[$];
    logic [1:0] mode;
    int err_count, checks_done;
    event rd_ev;
    vds_status_bank i_vds_status_bank (.core_clk(core_clk), .rst_n(rst_n),
        .core_state(cs), .vbi_result(vr), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_select(1'b0),
        .no_input_pin(nin_pin), .nonstandard_pin(nonstandard_input_flag_pin));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic check(input string nm, input logic [7:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done
    task automatic clks(input int n);
        repeat (n) @(posedge core_clk);
    endtask : clks
    // bus bits: data moves only while the serial clock is low
    task automatic put_bit(input logic b);
        sda_m <= b;
        clks(2);
        scl <= 1'b1;
        clks(4);
        scl <= 1'b0;
        clks(2);
    endtask : put_bit
    task automatic get_bit(output logic b);
        sda_m <= 1'b1;
        clks(2);
        scl <= 1'b1;
        clks(2);
        @(negedge core_clk);
        b = sda;
        clks(2);
        scl <= 1'b0;
        clks(2);
    endtask : get_bit
    task automatic start();
        sda_m <= 1'b1;
        clks(2);
        scl <= 1'b1;
        clks(4);
        sda_m <= 1'b0;
        clks(4);
        scl <= 1'b0;
        clks(2);
    endtask : start
    task automatic stop();
        sda_m <= 1'b0;
        clks(2);
        scl <= 1'b1;
        clks(4);
        sda_m <= 1'b1;
        clks(4);
    endtask : stop
    task automatic send(input logic [7:0] v);
        logic a;
        for (int i = 7; i >= 0; i--)
            put_bit(v[i]);
        get_bit(a);
        check("ack", {6'h00, sda_out, a}, 8'h00);
    endtask : send
    // n data bytes go to consecutive sub-addresses
    task automatic write_reg(input logic [7:0] sub, d, input int n = 1);
        start();
        send({DA, 1'b0});
        send(sub);
        for (int j = 0; j < n; j++)
            send(d);
        stop();
    endtask : write_reg
    // expected bytes are queued before the read goes out; a master ack
    // between bytes moves the read on to the next sub-address
    task automatic read_reg(input logic [7:0] sub, e, input int n = 1,
        input logic [7:0] e2 = 8'h00);
        logic [7:0] d;
        exp_q.push_back(e);
        if (n > 1)
            exp_q.push_back(e2);
        start();
        send({DA, 1'b0});
        send(sub);
        start();
        send({DA, 1'b1});
        for (int j = 1; j <= n; j++) begin
            for (int i = 7; i >= 0; i--)
                get_bit(d[i]);
            put_bit(j == n);
            rd_data = d;
            ->rd_ev;
        end
        stop();
    endtask : read_reg
    task automatic pulse(input logic [4:0] m, input logic [15:0] w);
        vr <= {m, w};
        clks(1);
        vr.done <= '0;
        clks(3);
    endtask : pulse
    // reserved clock code keeps the last reported mode
    function automatic logic [7:0] vs_exp(input vds_core_state_t s);
        logic ns;
        if (s.clock_mode != VDS_CLK_RESERVED)
            mode = s.clock_mode;
        ns = s.nonstandard_raw & ~(s.component_input & s.frame_standard_ok);
        return {s.colour_killer_active, s.even_field, mode, ns,
            s.frame_standard_ok, s.vertical_sync_locked, s.no_input};
    endfunction : vs_exp
    initial forever begin
        @(rd_ev);
        check("reg", rd_data, exp_q.pop_front());
    end
    initial begin
        #200000;
        err_count++;
        test_done();
    end
    initial begin
        logic [7:0] e, ss;
        logic [15:0] w;
        rst_n = 1'b0;
        scl = 1'b1;
        sda_m = 1'b1;
        cs = '0;
        vr = '0;
        mode = 2'b00;
        void'($urandom(5064));
        clks(10);
        rst_n <= 1'b1;
        clks(2);
        write_reg(VDS_SUB_VIDEO_STATUS, 8'hFF);
        for (int i = 0; i < 4; i++)
            read_reg(8'h20 + 8'(i), 8'h00);
        read_reg(8'h30, VDS_UNMAPPED_READ);
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            cs <= (i == 0) ? 12'h3A0 : 12'($urandom());
            clks(3);
            e = vs_exp(cs);
            check("no_input_pin", {7'h00, nin_pin}, {7'h00, e[0]});
            check("nonstd_pin", {7'h00, nonstandard_input_flag_pin}, {7'h00, e[3]});
            read_reg(VDS_SUB_VIDEO_STATUS, e);
            read_reg(VDS_SUB_SERVICE_STATUS, {cs[1:0], 6'h00});
        end
        $display("test status done");
        cs <= cs | 12'h004;
        w = 16'($urandom());
        pulse(5'h1F, w);
        read_reg(VDS_SUB_SERVICE_STATUS, {cs[1:0], 6'h00});
        write_reg(VDS_SUB_REQUEST, 8'h1F);
        w = 16'($urandom());
        pulse(5'h1F, w);
        ss = {cs[1:0], 1'b0, 4'hF, 1'b1};
        read_reg(VDS_SUB_SERVICE_STATUS, ss);
        read_reg(VDS_SUB_SERVICE_STATUS, ss);
        read_reg(VDS_SUB_CAPTION_LOW, w[7:0]);
        read_reg(VDS_SUB_CAPTION_HIGH, w[15:8]);
        for (int k = 1; k < 5; k++) begin
            write_reg(VDS_SUB_REQUEST - 8'h01, 8'h01 << k, 2);
            ss[k] = 1'b0;
            read_reg(VDS_SUB_SERVICE_STATUS, ss);
        end
        read_reg(VDS_SUB_CAPTION_LOW, w[7:0], 2, w[15:8]);
        $display("test services done");
        clks(4);
        test_done();
    end
endmodule : vds_status_bank_bench
`default_nettype wire
